// File: verilog/lbm_top.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Leaky-bucket activity monitor for one configuration set.
module lbm_top #(
    parameter int unsigned CYCLE_CLKS = 32'(lbm_pkg::LBM_CYCLE_CLKS)
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      fail_in,
    input  wire logic [lbm_pkg::LBM_AW-1:0] addr,
    input  wire logic [lbm_pkg::LBM_DW-1:0] wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [lbm_pkg::LBM_DW-1:0] rd_data,
    output logic                           alarm,
    output logic                           irq
);
    import lbm_pkg::*;

    // Cycle boundary pulse.
    logic tick;

    lbm_cycle_timer #(
        .CYCLE_CLKS (CYCLE_CLKS)
    ) u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // Configuration registers.
    logic [7:0]             upper_ff;
    logic [7:0]             nxt_upper;
    logic [7:0]             lower_ff;
    logic [7:0]             nxt_lower;
    logic [7:0]             size_ff;
    logic [7:0]             nxt_size;
    logic [LBM_DECAY_W-1:0] decay_ff;
    logic [LBM_DECAY_W-1:0] nxt_decay;
    logic [LBM_EV_W-1:0]    mask_ff;
    logic [LBM_EV_W-1:0]    nxt_mask;

    // Software writes land the cycle after the strobe.
    always_comb begin
        nxt_upper = upper_ff;
        nxt_lower = lower_ff;
        nxt_size  = size_ff;
        nxt_decay = decay_ff;
        nxt_mask  = mask_ff;
        if (wr_en) begin
            unique case (addr)
                LBM_OFF_UPPER: nxt_upper = wr_data;
                LBM_OFF_LOWER: nxt_lower = wr_data;
                LBM_OFF_SIZE:  nxt_size  = wr_data;
                LBM_OFF_DECAY:
                    nxt_decay = wr_data[LBM_DECAY_LSB +: LBM_DECAY_W];
                LBM_OFF_MASK:  nxt_mask  = wr_data[LBM_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Configuration flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_ff <= LBM_RST_UPPER;
            lower_ff <= LBM_RST_LOWER;
            size_ff  <= LBM_RST_SIZE;
            decay_ff <= LBM_RST_DECAY;
            mask_ff  <= LBM_RST_MASK;
        end else begin
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
            size_ff  <= nxt_size;
            decay_ff <= nxt_decay;
            mask_ff  <= nxt_mask;
        end
    end

    // Bucket state.
    logic                 seen_ff;
    logic                 nxt_seen;
    logic                 seen_now;
    logic [7:0]           cnt_ff;
    logic [7:0]           nxt_cnt;
    logic [LBM_RUN_W-1:0] run_ff;
    logic [LBM_RUN_W-1:0] nxt_run;
    logic [LBM_RUN_W-1:0] run_inc;

    // A failure seen in the boundary clock itself still counts for the
    // cycle that is closing, so no short glitch is lost.
    assign seen_now = seen_ff | fail_in;
    assign run_inc  = run_ff + 4'h1;

    // The count only moves on the boundary pulse. A lowered size takes
    // effect at the next boundary that sees a failure or ends a clean run, not mid-cycle.
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_run  = run_ff;
        nxt_seen = seen_now;
        if (tick) begin
            nxt_seen = 1'b0;
            if (seen_now) begin
                nxt_run = '0;
                if (cnt_ff >= size_ff) begin
                    nxt_cnt = size_ff;
                end else begin
                    nxt_cnt = cnt_ff + 8'h1;
                end
            end else if (run_inc >= lbm_decay_len(decay_ff)) begin
                nxt_run = '0;
                if (cnt_ff > size_ff) begin
                    nxt_cnt = size_ff;
                end else if (cnt_ff != 8'h0) begin
                    nxt_cnt = cnt_ff - 8'h1;
                end
            end else begin
                nxt_run = run_inc;
            end
        end
    end

    // Bucket flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_ff <= 1'b0;
            cnt_ff  <= 8'h0;
            run_ff  <= '0;
        end else begin
            seen_ff <= nxt_seen;
            cnt_ff  <= nxt_cnt;
            run_ff  <= nxt_run;
        end
    end

    // Alarm with hysteresis between the two thresholds.
    logic alarm_ff;
    logic nxt_alarm;

    always_comb begin
        nxt_alarm = alarm_ff;
        if (!alarm_ff && cnt_ff >= upper_ff) begin
            nxt_alarm = 1'b1;
        end else if (alarm_ff && cnt_ff <= lower_ff) begin
            nxt_alarm = 1'b0;
        end
    end

    // Sticky events: alarm raised and alarm cleared.
    logic [LBM_EV_W-1:0] ev_ff;
    logic [LBM_EV_W-1:0] nxt_ev;
    logic [LBM_EV_W-1:0] ev_set;
    logic                irq_ff;
    logic                nxt_irq;

    // A new event in the same cycle as a write-one-to-clear survives,
    // so software never loses an edge it has not yet seen.
    always_comb begin
        ev_set = '0;
        ev_set[LBM_EV_RAISE_BIT] = nxt_alarm & ~alarm_ff;
        ev_set[LBM_EV_CLEAR_BIT] = alarm_ff & ~nxt_alarm;
        nxt_ev = ev_ff;
        if (wr_en && addr == LBM_OFF_IRQ) begin
            nxt_ev = ev_ff & ~wr_data[LBM_EV_W-1:0];
        end
        nxt_ev  = nxt_ev | ev_set;
        nxt_irq = |(nxt_ev & nxt_mask);
    end

    // Alarm and interrupt flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_ff <= 1'b0;
            ev_ff    <= '0;
            irq_ff   <= 1'b0;
        end else begin
            alarm_ff <= nxt_alarm;
            ev_ff    <= nxt_ev;
            irq_ff   <= nxt_irq;
        end
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    always_comb begin
        nxt_rd = 8'h0;
        if (rd_en) begin
            unique case (addr)
                LBM_OFF_UPPER: nxt_rd = upper_ff;
                LBM_OFF_LOWER: nxt_rd = lower_ff;
                LBM_OFF_SIZE:  nxt_rd = size_ff;
                LBM_OFF_DECAY: nxt_rd[LBM_DECAY_W-1:0] = decay_ff;
                LBM_OFF_COUNT: nxt_rd = cnt_ff;
                LBM_OFF_STATUS: begin
                    nxt_rd[LBM_ST_ALARM_BIT] = alarm_ff;
                    nxt_rd[LBM_ST_SEEN_BIT]  = seen_ff;
                end
                LBM_OFF_IRQ:   nxt_rd[LBM_EV_W-1:0] = ev_ff;
                LBM_OFF_MASK:  nxt_rd[LBM_EV_W-1:0] = mask_ff;
                default: ;
            endcase
        end
    end

    // Read data flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff <= 8'h0;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    assign rd_data = rd_ff;
    assign alarm   = alarm_ff;
    assign irq     = irq_ff;

    // Checks on the boundary pulse, the bucket, the alarm and the interrupt.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_cnt_only_tick: assert property (
        !tick |=> $stable(cnt_ff)
    ) else $error("bucket count moved between cycle boundaries");

    a_tick_spacing: assert property (
        tick |=> !tick [*2]
    ) else $error("cycle boundaries too close together");

    a_fill_one: assert property (
        tick && seen_now && cnt_ff < size_ff
        |=> cnt_ff == $past(cnt_ff) + 8'h1
    ) else $error("failed cycle did not add exactly one");

    a_drain_one: assert property (
        tick && !seen_now && cnt_ff != 8'h0 && cnt_ff <= size_ff
        && run_inc == lbm_decay_len(decay_ff)
        |=> cnt_ff == $past(cnt_ff) - 8'h1
    ) else $error("clean run did not drain one");

    a_drain_wait: assert property (
        tick && !seen_now && run_inc < lbm_decay_len(decay_ff)
        |=> $stable(cnt_ff) && run_ff == $past(run_inc)
    ) else $error("bucket drained before run was complete");

    a_size_cap: assert property (
        tick && seen_now && cnt_ff >= size_ff
        |=> cnt_ff == $past(size_ff)
    ) else $error("bucket grew past its size");

    a_alarm_raise: assert property (
        !alarm_ff && cnt_ff >= upper_ff |=> alarm_ff ##1 alarm
    ) else $error("alarm not raised at upper threshold");

    a_alarm_hold: assert property (
        alarm_ff && cnt_ff > lower_ff |=> alarm_ff
    ) else $error("alarm cleared above lower threshold");

    a_alarm_drop: assert property (
        alarm_ff && cnt_ff <= lower_ff |=> !alarm_ff
    ) else $error("alarm held at lower threshold");

    a_irq_level: assert property (
        ##1 irq_ff == |(ev_ff & mask_ff)
    ) else $error("interrupt does not follow masked status");

    // Checks on the bucket floor and cap, the run counter, the failure
    // flag, the events and the read port. A size write is excluded from
    // the cap check because a lowered size only bites at a boundary that
    // sees a failure or ends a clean run.
    a_floor_zero: assert property (
        tick && !seen_now && cnt_ff == 8'h0 |=> cnt_ff == 8'h0
    ) else $error("bucket drained below zero");

    a_fill_run_clr: assert property (
        tick && seen_now |=> run_ff == '0
    ) else $error("failed cycle did not restart the clean run");

    a_cap_hold: assert property (
        cnt_ff <= size_ff && !(wr_en && addr == LBM_OFF_SIZE)
        |=> cnt_ff <= size_ff
    ) else $error("bucket count rose above its size");

    a_seen_restart: assert property (
        tick |=> !seen_ff
    ) else $error("failure flag carried across a cycle boundary");

    a_seen_mark: assert property (
        fail_in && !tick |=> seen_ff
    ) else $error("failure not remembered for the cycle");

    a_ev_raise: assert property (
        $rose(alarm_ff) |-> ev_ff[LBM_EV_RAISE_BIT]
    ) else $error("alarm raise event not recorded");

    a_ev_clear: assert property (
        $fell(alarm_ff) |-> ev_ff[LBM_EV_CLEAR_BIT]
    ) else $error("alarm clear event not recorded");

    a_rd_idle: assert property (
        !rd_en |=> rd_data == 8'h0
    ) else $error("read data present without a read strobe");

endmodule

// File: verilog/lbm_pkg.sv
// Behaviour
// - Evaluate once per 128 ms cycle, at boundaries.
// - Failed or erratic cycle adds one.
// - Each 1/2/4/8 clean cycles subtract one, floor zero.
// - Count saturates at the programmed bucket size.
// - Count reaching upper threshold raises the alarm.
package lbm_pkg;

    // Register port widths.
    localparam int LBM_AW = 8;
    localparam int LBM_DW = 8;

    // Register offsets.
    localparam logic [7:0] LBM_OFF_UPPER  = 8'h54;
    localparam logic [7:0] LBM_OFF_LOWER  = 8'h55;
    localparam logic [7:0] LBM_OFF_SIZE   = 8'h56;
    localparam logic [7:0] LBM_OFF_DECAY  = 8'h57;
    localparam logic [7:0] LBM_OFF_COUNT  = 8'h58;
    localparam logic [7:0] LBM_OFF_STATUS = 8'h59;
    localparam logic [7:0] LBM_OFF_IRQ    = 8'h5a;
    localparam logic [7:0] LBM_OFF_MASK   = 8'h5b;

    // Reset values.
    localparam logic [7:0] LBM_RST_UPPER = 8'h06;
    localparam logic [7:0] LBM_RST_LOWER = 8'h04;
    localparam logic [7:0] LBM_RST_SIZE  = 8'h08;
    localparam logic [1:0] LBM_RST_DECAY = 2'h1;
    localparam logic [1:0] LBM_RST_MASK  = 2'h0;

    // Field positions.
    localparam int LBM_DECAY_LSB    = 0;
    localparam int LBM_DECAY_W      = 2;
    localparam int LBM_EV_RAISE_BIT = 0;
    localparam int LBM_EV_CLEAR_BIT = 1;
    localparam int LBM_EV_W         = 2;
    localparam int LBM_ST_ALARM_BIT = 0;
    localparam int LBM_ST_SEEN_BIT  = 1;

    // Observation cycle timing.
    localparam longint LBM_CLK_HZ   = 64'd40000000;
    localparam longint LBM_CYCLE_MS = 64'd128;
    localparam longint LBM_CYCLE_CLKS = LBM_CYCLE_MS * LBM_CLK_HZ / 64'd1000;

    // Width of the clean-run counter, enough for a run of eight.
    localparam int LBM_RUN_W = 4;

    // Number of clean cycles per decrement for a decay setting.
    function automatic logic [LBM_RUN_W-1:0] lbm_decay_len(
        input logic [LBM_DECAY_W-1:0] rate
    );
        lbm_decay_len = 4'h1 << rate;
    endfunction

endpackage

// File: verilog/lbm_cycle_timer.sv
`timescale 1ns/1ps
// Emits a one-clock pulse at the end of each observation cycle.
module lbm_cycle_timer #(
    parameter int unsigned CYCLE_CLKS = 32'(lbm_pkg::LBM_CYCLE_CLKS)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    import lbm_pkg::*;

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        tick_ff;
    logic        nxt_tick;

    // Free-running divider; the pulse comes from a flop so that the
    // bucket sees a clean boundary.
    always_comb begin
        nxt_tick = 1'b0;
        if (cnt_ff == CYCLE_CLKS - 1) begin
            nxt_cnt  = 32'h0;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 32'h1;
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench: register reset values, fill, saturation,
// hysteresis, interrupt masking and every decay setting.
module testbench;
    import lbm_pkg::*;
    // A short observation cycle keeps the run brief.
    localparam int CYC = 16;
    localparam logic [7:0] RST_TAB [8] = '{LBM_RST_UPPER, LBM_RST_LOWER,
        LBM_RST_SIZE, {6'h0, LBM_RST_DECAY}, 8'h00, 8'h00, 8'h00,
        {6'h0, LBM_RST_MASK}};
    logic       clk;
    logic       rst_n;
    logic       fail_in;
    logic       wr_en;
    logic       rd_en;
    logic       rd_p;
    logic       alarm;
    logic       irq;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] v;
    logic [7:0] exp_q [$];
    int         n_errors;
    int         checked;
    int         ecnt;
    int         seed;
    int         base;

    lbm_top #(.CYCLE_CLKS(CYC)) lbm_top_inst (
        .clk     (clk),
        .rst_n   (rst_n),
        .fail_in (fail_in),
        .addr    (addr),
        .wr_data (wr_data),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .alarm   (alarm),
        .irq     (irq)
    );

    // Free-running clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Edge count since reset release, used to stay mid-cycle.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ecnt <= 0;
        end else begin
            ecnt <= ecnt + 1;
        end
    end

    // Read data stand only one cycle, so they are checked mid-cycle.
    always @(posedge clk) begin
        rd_p <= rd_en;
    end
    always @(negedge clk) begin
        if (rd_p === 1'b1) begin
            chk(rd_data, exp_q.pop_front());
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // Boundaries are avoided: every check after the register tests sits in the middle of a cycle.
    task automatic sync(input int k);
        while (ecnt < k * CYC + CYC / 2) @(posedge clk);
    endtask

    task automatic pins(input logic ea, input logic ei);
        @(negedge clk);
        chk_pin(alarm, ea);
        chk_pin(irq, ei);
    endtask

    task automatic end_of_test();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the roughly 660 edges of the tests.
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        seed = 66;
        rst_n = 1'b0;
        fail_in = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        n_errors = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(LBM_OFF_UPPER + 8'(i), RST_TAB[i]);
        end
        rd(8'h60, 8'h00);
        wr(LBM_OFF_COUNT, 8'h77);
        rd(LBM_OFF_COUNT, 8'h00);
        v = 8'($random(seed));
        wr(LBM_OFF_LOWER, v);
        rd(LBM_OFF_LOWER, v);
        v = 8'($random(seed));
        wr(LBM_OFF_SIZE, v);
        rd(LBM_OFF_SIZE, v);
        $display("test registers done");
        wr(LBM_OFF_UPPER, 8'h03);
        wr(LBM_OFF_LOWER, 8'h01);
        wr(LBM_OFF_SIZE, 8'h04);
        wr(LBM_OFF_DECAY, 8'h00);
        wr(LBM_OFF_MASK, 8'h01);
        // Bad from cycle 4 through cycle 10, then clean.
        sync(4);
        fail_in <= 1'b1;
        sync(5);
        rd(LBM_OFF_COUNT, 8'h01);
        sync(7);
        rd(LBM_OFF_COUNT, 8'h03);
        pins(1'b1, 1'b1);
        rd(LBM_OFF_STATUS, 8'h03);
        sync(10);
        rd(LBM_OFF_COUNT, 8'h04);
        fail_in <= 1'b0;
        sync(12);
        rd(LBM_OFF_COUNT, 8'h03);
        pins(1'b1, 1'b1);
        wr(LBM_OFF_IRQ, 8'h01);
        repeat (2) @(posedge clk);
        pins(1'b1, 1'b0);
        wr(LBM_OFF_MASK, 8'h03);
        sync(14);
        rd(LBM_OFF_COUNT, 8'h01);
        pins(1'b0, 1'b1);
        rd(LBM_OFF_IRQ, 8'h02);
        wr(LBM_OFF_IRQ, 8'h02);
        pins(1'b0, 1'b0);
        sync(17);
        rd(LBM_OFF_COUNT, 8'h00);
        $display("test fill and drain done");
        // One bad cycle, then exactly the decay length of clean ones.
        base = 18;
        for (int r = 0; r < 4; r++) begin
            sync(base);
            wr(LBM_OFF_DECAY, 8'(r));
            @(posedge clk);
            fail_in <= 1'b1;
            @(posedge clk);
            fail_in <= 1'b0;
            sync(base + (1 << r));
            rd(LBM_OFF_COUNT, 8'h01);
            sync(base + (1 << r) + 1);
            rd(LBM_OFF_COUNT, 8'h00);
            base += (1 << r) + 2;
        end
        repeat (2) @(posedge clk);
        $display("test decay rates done");
        end_of_test();
    end
endmodule
